//--- core/mode_config_port.sv
// Operation
// - sleep powers down everything, from register in serial or SCK in parallel.
// - serial mode can disable channel B alone, channel A keeps running.
// - nap powers core down, reference stays; wake needs 100 clocks.
// - nap is only reachable through power_down_register in serial mode.
// - strap high means parallel static pins, low means serial port.
// - parallel CS pin turns duty-cycle stabilizer off at 0, on at 1.
// - parallel SCK pin: 0 normal, 1 whole converter sleeps.
// - parallel SDI pin: 0 selects 3.5 mA, 1 selects 1.75 mA drive.
// - transfer framed by CS low; first sixteen SCK rises sampled, rest ignored.
// - word is read flag, seven address bits, eight data bits, MSB first.
// - read flag low stores the data byte in the addressed register.
// - read flag high returns register on SDO, no update, SDI data ignored.
// - SDO is open drain: only pulls low, otherwise released.
// - writing 1 to D7 of reset_register clears all mode register bits.
// - reset trigger self-clears; reset_register is write only.
// - unused register bits read back as zero.
// - power_down_register bit 3 is sleep: 1 powers down entire converter.
`timescale 1ns/1ps
`include "mode_port_params.svh"

module mode_config_port (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // strap and configuration pins
  input  wire logic                        prog_mode_select,
  input  wire mode_port_pkg::serial_pins_type pins_in,
  input  wire logic                        sample_tick,
  // open-drain readback pin
  output logic                             sdo_out,
  output logic                             sdo_oe,
  // resulting mode controls
  output mode_port_pkg::mode_ctrl_type     mode_out,
  output logic                             chb_enabled,
  output logic                             core_settled
);
  import mode_port_pkg::*;

  logic [3:0] sync_bits;
  logic       strap_s;
  logic       cs_n_s;
  logic       sck_s;
  logic       sdi_s;

  pin_sync #(.WIDTH(4)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({prog_mode_select, pins_in.cs_n, pins_in.sck, pins_in.sdi}),
    .sync_out (sync_bits)
  );

  assign strap_s = sync_bits[3];
  assign cs_n_s  = sync_bits[2];
  assign sck_s   = sync_bits[1];
  assign sdi_s   = sync_bits[0];

  // serial shifter state
  xfer_state_type state_r,    state_nxt;
  logic           sck_d_r,    sck_d_nxt;
  logic [4:0]     bit_cnt_r,  bit_cnt_nxt;
  logic [15:0]    shift_r,    shift_nxt;
  logic           rd_flag_r,  rd_flag_nxt;
  logic [7:0]     rd_data_r,  rd_data_nxt;
  logic           sdo_low_r,  sdo_low_nxt;
  // register file
  logic [7:0]     pd_reg_r,   pd_reg_nxt;
  logic [2:0]     cur_reg_r,  cur_reg_nxt;
  logic           dcs_reg_r,  dcs_reg_nxt;
  logic           trig_r,     trig_nxt;
  // resulting mode controls
  mode_ctrl_type  mode_r,     mode_nxt;
  logic           chb_en_r,   chb_en_nxt;
  // decoded strobes
  logic           serial_mode;
  logic           sck_rise;
  logic           word_done;
  logic           wr_strobe;
  logic [6:0]     wr_addr;
  logic [7:0]     wr_data;
  logic           powered_down;
  logic           settled;

  assign serial_mode = !strap_s;
  // sck rests low, so the reset value of sck_d_r gives no false edge
  assign sck_rise    = sck_s && !sck_d_r;

  // readback value per address; unused bits forced low
  function automatic logic [7:0] read_reg(input logic [6:0] addr,
                                          input logic [7:0] pd,
                                          input logic [2:0] cur,
                                          input logic       dcs);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      `REG_IDX_POWER_DOWN:     val = pd & `PD_USED_MASK;
      `REG_IDX_OUTPUT_CURRENT: val = {4'h0, dcs, cur};
      default:                 val = 8'h00;
    endcase
    return val;
  endfunction

  // parallel drive-current pin to current code
  function automatic logic [2:0] par_current(input logic pin);
    logic [2:0] code;
    code = `CUR_CODE_3P5MA;
    if (pin) begin
      code = `CUR_CODE_1P75MA;
    end
    return code;
  endfunction

  // serial frame shifter
  always_comb begin
    state_nxt   = state_r;
    sck_d_nxt   = sck_s;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    rd_flag_nxt = rd_flag_r;
    rd_data_nxt = rd_data_r;
    word_done   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        bit_cnt_nxt = 5'h00;
        rd_flag_nxt = 1'b0;
        if (serial_mode && !cs_n_s) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_n_s || !serial_mode) begin
          // a cut frame leaves without ever raising the write strobe
          state_nxt = ST_IDLE;
        end else if (sck_rise) begin
          shift_nxt   = {shift_r[14:0], sdi_s};
          bit_cnt_nxt = bit_cnt_r + 5'h01;
          if (bit_cnt_r == 5'h07) begin
            // flag and address are complete with the eighth bit
            rd_flag_nxt = shift_r[6];
            rd_data_nxt = read_reg({shift_r[5:0], sdi_s}, pd_reg_r,
                                   cur_reg_r, dcs_reg_r);
          end else if (bit_cnt_r > 5'h07) begin
            // host sampled the bit on this rise, present the next one
            rd_data_nxt = {rd_data_r[6:0], 1'b0};
          end
          if (bit_cnt_r == 5'(`WORD_BITS - 1)) begin
            word_done = 1'b1;
            state_nxt = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // later edges in this frame are ignored
        if (cs_n_s || !serial_mode) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // open drain: only ever pull low, in the last eight bit times of a read
  always_comb begin
    sdo_low_nxt = rd_flag_nxt && (state_nxt == ST_SHIFT) &&
                  (bit_cnt_nxt >= 5'h08) && !rd_data_nxt[7];
  end

  assign wr_strobe = word_done && !shift_nxt[15];
  assign wr_addr   = shift_nxt[14:8];
  assign wr_data   = shift_nxt[7:0];

  // mode register file
  always_comb begin
    pd_reg_nxt  = pd_reg_r;
    cur_reg_nxt = cur_reg_r;
    dcs_reg_nxt = dcs_reg_r;
    // trigger lives one cycle only; read_reg has no entry for it, so it reads back as zero
    trig_nxt    = 1'b0;
    if (trig_r) begin
      pd_reg_nxt  = `MODE_REG_RESET;
      cur_reg_nxt = 3'(`MODE_REG_RESET);
      dcs_reg_nxt = 1'(`MODE_REG_RESET);
    end else if (wr_strobe) begin
      case (wr_addr)
        `REG_IDX_SOFT_RESET: begin
          trig_nxt = wr_data[`RST_BIT_TRIGGER];
        end
        `REG_IDX_POWER_DOWN: begin
          pd_reg_nxt = wr_data & `PD_USED_MASK;
        end
        `REG_IDX_OUTPUT_CURRENT: begin
          cur_reg_nxt = wr_data[2:0];
          dcs_reg_nxt = wr_data[3];
        end
        default: begin
          pd_reg_nxt = pd_reg_r;
        end
      endcase
    end
  end

  // mode selection: register file in serial mode, static pins otherwise
  always_comb begin
    mode_nxt = '0;
    if (serial_mode) begin
      mode_nxt.stabilizer_on = dcs_reg_r;
      mode_nxt.sleep         = pd_reg_r[`PD_BIT_SLEEP];
      mode_nxt.nap           = pd_reg_r[`PD_BIT_NAP];
      mode_nxt.chb_off       = pd_reg_r[`PD_BIT_CHB_OFF];
      mode_nxt.drv_current   = cur_reg_r;
    end else begin
      mode_nxt.stabilizer_on = cs_n_s;
      mode_nxt.sleep         = sck_s;
      mode_nxt.nap           = 1'b0;
      mode_nxt.chb_off       = 1'b0;
      mode_nxt.drv_current   = par_current(sdi_s);
    end
    // channel a is untouched by the channel b control
    chb_en_nxt = !mode_nxt.chb_off;
  end

  assign powered_down = mode_r.sleep || mode_r.nap;

  nap_wake_timer #(.WAKE_CYCLES(`NAP_WAKE_CYCLES)) u_wake (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .powered_down (powered_down),
    .sample_tick  (sample_tick),
    .settled      (settled)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      sck_d_r   <= 1'b0;
      bit_cnt_r <= 5'h00;
      shift_r   <= 16'h0000;
      rd_flag_r <= 1'b0;
      rd_data_r <= 8'h00;
      sdo_low_r <= 1'b0;
      pd_reg_r  <= `MODE_REG_RESET;
      cur_reg_r <= 3'(`MODE_REG_RESET);
      dcs_reg_r <= 1'(`MODE_REG_RESET);
      trig_r    <= 1'b0;
      mode_r    <= '0;
      chb_en_r  <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      sck_d_r   <= sck_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      rd_flag_r <= rd_flag_nxt;
      rd_data_r <= rd_data_nxt;
      sdo_low_r <= sdo_low_nxt;
      pd_reg_r  <= pd_reg_nxt;
      cur_reg_r <= cur_reg_nxt;
      dcs_reg_r <= dcs_reg_nxt;
      trig_r    <= trig_nxt;
      mode_r    <= mode_nxt;
      chb_en_r  <= chb_en_nxt;
    end
  end

  assign sdo_oe       = sdo_low_r;
  assign sdo_out      = !sdo_low_r;
  assign mode_out     = mode_r;
  assign chb_enabled  = chb_en_r;
  assign core_settled = settled;

  sequence s_reset_write;
    wr_strobe && (wr_addr == `REG_IDX_SOFT_RESET) && wr_data[`RST_BIT_TRIGGER];
  endsequence

  sequence s_regs_cleared;
    trig_r ##1 (!trig_r && (pd_reg_r == `MODE_REG_RESET) && (cur_reg_r == 3'h0) &&
                !dcs_reg_r);
  endsequence

  chk_soft_reset_clear: assert property (@(posedge ref_clk) disable iff (rst)
    s_reset_write |=> s_regs_cleared)
    else $error("software reset did not clear the mode registers");

  chk_sdo_drive_low: assert property (@(posedge ref_clk) disable iff (rst)
    sdo_oe |-> !sdo_out)
    else $error("readback pin driven high");

  chk_edge_limit: assert property (@(posedge ref_clk) disable iff (rst)
    bit_cnt_r <= 5'(`WORD_BITS))
    else $error("more than sixteen bits taken in one frame");

  chk_par_no_nap: assert property (@(posedge ref_clk) disable iff (rst)
    !serial_mode |=> !mode_r.nap)
    else $error("nap reached in parallel mode");

  chk_par_sleep_pin: assert property (@(posedge ref_clk) disable iff (rst)
    !serial_mode |=> (mode_r.sleep == $past(sck_s)))
    else $error("parallel sleep does not follow its pin");

  chk_sleep_bit: assert property (@(posedge ref_clk) disable iff (rst)
    serial_mode |=> (mode_r.sleep == $past(pd_reg_r[`PD_BIT_SLEEP])))
    else $error("serial sleep does not follow its register bit");

  chk_read_keeps_reg: assert property (@(posedge ref_clk) disable iff (rst)
    (word_done && shift_nxt[15] && !trig_r) |=> $stable(pd_reg_r))
    else $error("read frame changed a register");

  chk_cut_no_write: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_SHIFT && cs_n_s) |-> !wr_strobe)
    else $error("write strobe on an aborted frame");

endmodule

//--- core/mode_port_params.svh
`ifndef MODE_PORT_PARAMS_SVH
`define MODE_PORT_PARAMS_SVH

// register indices (address field A6:A0)
`define REG_IDX_SOFT_RESET      7'h00
`define REG_IDX_POWER_DOWN      7'h01
`define REG_IDX_OUTPUT_CURRENT  7'h03
// power_down_register field positions
`define PD_BIT_SLEEP            3
`define PD_BIT_NAP              2
`define PD_BIT_CHB_OFF          1
`define PD_USED_MASK            8'h0E
// soft_reset_ctrl trigger bit
`define RST_BIT_TRIGGER         7
// reset value of every mode control register
`define MODE_REG_RESET          8'h00
// output driver current code for 1.75 mA, 3.5 mA is code zero
`define CUR_CODE_1P75MA         3'h1
`define CUR_CODE_3P5MA          3'h0
// serial word geometry
`define WORD_BITS               16
// nap wake-up in sampling clocks
`define NAP_WAKE_CYCLES         100

`endif

//--- core/mode_port_pkg.sv
package mode_port_pkg;

  typedef struct packed {
    logic       stabilizer_on;
    logic       sleep;
    logic       nap;
    logic       chb_off;
    logic [2:0] drv_current;
  } mode_ctrl_type;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } serial_pins_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } xfer_state_type;

endpackage

//--- core/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // pins
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

//--- core/nap_wake_timer.sv
`timescale 1ns/1ps

module nap_wake_timer #(
  parameter int WAKE_CYCLES = 100
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // power-down level and sampling clock tick
  input  wire logic powered_down,
  input  wire logic sample_tick,
  output logic      settled
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (powered_down) begin
      count_nxt = 8'h00;
    end else if (sample_tick && (count_r < 8'(WAKE_CYCLES))) begin
      count_nxt = count_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_r <= 8'(WAKE_CYCLES);
    end else begin
      count_r <= count_nxt;
    end
  end

  // core counts as ready only after the full nap recovery span
  assign settled = !powered_down && (count_r >= 8'(WAKE_CYCLES));

  chk_wake_wait: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(powered_down) |-> !settled)
    else $error("converter reported settled right after power-down ended");

endmodule

//--- verification/host_model.sv
`timescale 1ns/1ps
module host_model
  import mode_port_pkg::*;
(
  // clock
  input  wire logic            ref_clk,
  // parallel strap levels
  input  wire logic            par_en,
  input  wire serial_pins_type par_pins,
  // open-drain readback
  input  wire logic            sdo_out,
  input  wire logic            sdo_oe,
  // pins toward the device
  output serial_pins_type      pins
);
  serial_pins_type ser;
  logic            sdo_line;
  // external pull-up gives the high level whenever the device lets go
  assign sdo_line = (sdo_oe === 1'b1 && sdo_out === 1'b0) ? 1'b0 : 1'b1;
  assign pins = par_en ? par_pins : ser;
  initial ser = 3'b100;
  // sdi flips while idle so a stale level never looks like data
  always @(posedge ref_clk) if (ser.cs_n) ser.sdi <= ~ser.sdi;
  // n rising sck edges, 400 ns apart; sck rests low outside frames
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk) ser.cs_n <= 1'b0;
    @(posedge ref_clk) ser.sdi <= w[15];
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge ref_clk);
      ser.sck <= 1'b1;
      if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line};
      repeat (4) @(posedge ref_clk);
      ser.sck <= 1'b0;
      ser.sdi <= (i < 15) ? w[14-i] : ~ser.sdi;
    end
    repeat (4) @(posedge ref_clk);
    ser.cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

//--- verification/adc_mode_config_port_bench.sv
`timescale 1ns/1ps
module adc_mode_config_port_bench;
  import mode_port_pkg::*;
  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  logic            prog_mode_select = 1'b0;
  logic            sample_tick = 1'b0;
  logic            par_en = 1'b0;
  serial_pins_type par_pins = 3'b000;
  serial_pins_type pins;
  logic            sdo_out;
  logic            sdo_oe;
  mode_ctrl_type   mode_out;
  logic            chb_enabled;
  logic            core_settled;
  logic [15:0]     seed = 16'hC32B;
  int              num_errors = 0;
  int              checked = 0;
  int              cycles = 0;

  initial forever #25 ref_clk = ~ref_clk;

  mode_config_port dut (.ref_clk(ref_clk), .rst(rst), .prog_mode_select(prog_mode_select),
    .pins_in(pins), .sample_tick(sample_tick), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .mode_out(mode_out), .chb_enabled(chb_enabled), .core_settled(core_settled));
  host_model host (.ref_clk(ref_clk), .par_en(par_en), .par_pins(par_pins),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .pins(pins));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // only sleep, nap and channel-b-off bits exist
  function automatic logic [7:0] pd_exp(input logic [7:0] v);
    return v & 8'h0E;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // sampling clock keeps ticking at random through nap
  always @(posedge ref_clk) begin
    seed <= lfsr(seed);
    sample_tick <= seed[0];
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      finish_test();
    end
  end
  always @(negedge ref_clk) if (sdo_oe === 1'b1) chk({7'h00, sdo_out}, 8'h00);

  initial begin
    logic [7:0] rd;
    logic [7:0] v;
    int         n;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    host.xfer(16'h0080, 16, rd);
    host.xfer(16'h8000, 16, rd);
    chk(rd, 8'h00);
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'hFF : seed[7:0];
      host.xfer({8'h01, v}, 16, rd);
      host.xfer({8'h81, ~v}, 16, rd);
      chk(rd, pd_exp(v));
      chk({5'h00, mode_out.sleep, mode_out.nap, mode_out.chb_off}, pd_exp(v) >> 1);
      chk({7'h00, chb_enabled}, {7'h00, ~v[1]});
    end
    host.xfer({8'h01, ~v}, 10, rd);
    host.xfer(16'h8100, 16, rd);
    chk(rd, pd_exp(v));
    host.xfer(16'h0104, 20, rd);
    host.xfer(16'h8100, 16, rd);
    chk(rd, 8'h04);
    host.xfer(16'h0100, 16, rd);
    n = 0;
    for (int c = 0; c < 2000 && core_settled !== 1'b1; c++) begin
      @(posedge ref_clk);
      if (sample_tick === 1'b1) n++;
    end
    // the transfer tail already spends up to twelve ticks
    chk({7'h00, core_settled}, 8'h01);
    chk({7'h00, n >= 88}, 8'h01);
    host.xfer(16'h0108, 16, rd);
    host.xfer(16'h0100, 16, rd);
    // data is distrusted for 0.1 ms plus 2500 sample clocks after sleep
    repeat (2000) @(posedge ref_clk);
    n = 0;
    while (n < 2500) begin
      @(posedge ref_clk);
      if (sample_tick === 1'b1) n++;
    end
    chk({7'h00, core_settled}, 8'h01);
    host.xfer(16'h030D, 16, rd);
    host.xfer(16'h8300, 16, rd);
    chk(rd, 8'h0D);
    chk({5'h00, mode_out.drv_current}, 8'h05);
    host.xfer(16'h010E, 16, rd);
    host.xfer(16'h0080, 16, rd);
    host.xfer(16'h8100, 16, rd);
    chk(rd, 8'h00);
    host.xfer(16'h8300, 16, rd);
    chk(rd, 8'h00);
    host.xfer(16'h8000, 16, rd);
    chk(rd, 8'h00);
    host.xfer(16'h0104, 16, rd);
    prog_mode_select <= 1'b1;
    par_en <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      par_pins <= k[2:0];
      repeat (8) @(posedge ref_clk);
      chk({5'h00, mode_out.stabilizer_on, mode_out.sleep, mode_out.nap},
          {5'h00, k[2], k[1], 1'b0});
      chk({5'h00, mode_out.drv_current}, {5'h00, k[0] ? 3'h1 : 3'h0});
      chk({7'h00, sdo_oe}, 8'h00);
    end
    finish_test();
  end
endmodule
